// >>> occ_channel.sv
// output compare channel with single edge, dual edge, pwm and pulse modes
// Behaviour
// - The timer count is compared every cycle against one or two compare values as the mode requires.
// - A match yields one output edge or a running pulse train depending on the mode.
// - Every compare match event can raise an interrupt request.
// - Selector 0001 drives the output high on a match, with bit 5 choosing 16-bit or 32-bit compare.
// - Selector 0010 drives the output low on a match, with 16-bit or 32-bit compare.
// - Selector 0011 inverts the output on every match, with 16-bit or 32-bit compare.
// - Selector 0100 with 16-bit width sets the output on the first value and clears it on the second.
// - Selector 0101 with 16-bit width does the same using compare values buffered at period end.
// - Selector 0110 with 16-bit width makes center aligned pulses from buffered compare values.
// - Selector 0111 makes a variable frequency pulse output, 16-bit or 32-bit.
module occ_channel
  import occ_pkg::*;
#(
  parameter int CW = 32
)(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // control, channel_control_low bits 7:0
  input  wire logic [7:0]    channel_control_low,
  // timer and compare values
  input  wire logic [CW-1:0] timer_count,
  input  wire logic [CW-1:0] cmp_a,
  input  wire logic [CW-1:0] cmp_b,
  input  wire logic          period_end,
  // outputs
  output logic               cmp_out,
  output logic               match_irq,
  output logic               match_a,
  output logic               match_b
);
  import occ_pkg::*;

  // width of every 16-bit comparison
  localparam int NW = 16;
  // compare units: first value, then second value
  localparam int NU = 2;
  // unit that holds the first compare value
  localparam int FIRST_UNIT = 0;
  // unit that holds the second compare value
  localparam int SECOND_UNIT = 1;

  // compare with chosen width
  function automatic logic cmp_eq(input logic [CW-1:0] t, input logic [CW-1:0] c, input logic w);
    cmp_eq = w ? (t == c) : (t[NW-1:0] == c[NW-1:0]);
  endfunction

  // selector and width to operating mode
  function automatic occ_mode_t decode_mode(input logic [3:0] s, input logic w);
    case (s)
      SEL_OFF:    decode_mode = OCC_OFF;
      SEL_HIGH:   decode_mode = OCC_HIGH;
      SEL_LOW:    decode_mode = OCC_LOW;
      SEL_TOGGLE: decode_mode = OCC_TOGGLE;
      SEL_DUAL:   decode_mode = w ? OCC_BAD : OCC_DUAL;
      SEL_DUALB:  decode_mode = w ? OCC_BAD : OCC_DUALB;
      SEL_CENTER: decode_mode = w ? OCC_BAD : OCC_CENTER;
      SEL_VFREQ:  decode_mode = OCC_VFREQ;
      default:    decode_mode = OCC_OFF;
    endcase
  endfunction

  // modes with a single compare value
  function automatic logic is_single(input occ_mode_t m);
    case (m)
      OCC_HIGH, OCC_LOW, OCC_TOGGLE, OCC_VFREQ: is_single = 1'b1;
      default:                                  is_single = 1'b0;
    endcase
  endfunction

  // modes with a set value and a clear value
  function automatic logic is_dual(input occ_mode_t m);
    case (m)
      OCC_DUAL, OCC_DUALB, OCC_CENTER: is_dual = 1'b1;
      default:                         is_dual = 1'b0;
    endcase
  endfunction

  // modes that compare against the buffered copies
  function automatic logic is_buffered(input occ_mode_t m);
    case (m)
      OCC_DUALB, OCC_CENTER: is_buffered = 1'b1;
      default:               is_buffered = 1'b0;
    endcase
  endfunction

  // mode decode and selector history
  occ_mode_t            mode;
  logic [3:0]           sel;
  logic                 wide;
  logic [3:0]           sel_q, sel_d;
  logic                 reload;
  // per unit hits, gathered from the generate loop
  logic [NU-1:0]        hit;
  logic                 hit_a, hit_b;
  // output level and match events
  logic                 out_q, out_d;
  logic                 irq_q, irq_d;
  logic                 ma_q, ma_d;
  logic                 mb_q, mb_d;

  // selector and width fields of the control byte
  assign sel  = channel_control_low[MODE_MSB:MODE_LSB];
  assign wide = channel_control_low[WIDE_BIT];

  // decode selector and width into a mode
  always_comb
  begin
    mode = decode_mode(sel, wide);
  end

  // buffers reload at period end or on any selector change
  always_comb
  begin
    reload = period_end || (sel != sel_q);
  end

  // selector history, next value
  always_comb
  begin
    sel_d = sel;
  end

  // selector history register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= CTRL_RESET[MODE_MSB:MODE_LSB];
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  // one compare unit per compare value
  genvar u;
  generate
    for (u = 0; u < NU; u = u + 1)
    begin : g_unit
      // the first unit also serves the single value modes
      localparam logic FIRST = (u == FIRST_UNIT);
      logic [CW-1:0] live_val;
      logic [CW-1:0] buf_q, buf_d;
      logic          hit_c;

      // live compare value of this unit
      assign live_val = FIRST ? cmp_a : cmp_b;

      // buffered copy, next value
      always_comb
      begin
        buf_d = buf_q;
        if (reload)
        begin
          buf_d = live_val;
        end
      end

      // buffered copy register, so a period runs on stable values
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          buf_q <= '0;
        end
        else
        begin
          buf_q <= buf_d;
        end
      end

      // compare against the live or the buffered value
      always_comb
      begin
        hit_c = 1'b0;
        if (is_buffered(mode))
        begin
          hit_c = cmp_eq(timer_count, buf_q, 1'b0);
        end
        else if (is_dual(mode))
        begin
          hit_c = cmp_eq(timer_count, live_val, 1'b0);
        end
        else if (FIRST && is_single(mode))
        begin
          hit_c = cmp_eq(timer_count, live_val, wide);
        end
        else
        begin
          hit_c = 1'b0;
        end
      end

      assign hit[u] = hit_c;
    end
  endgenerate

  // named hits of the two compare values
  assign hit_a = hit[FIRST_UNIT];
  assign hit_b = hit[SECOND_UNIT];

  // next output level
  always_comb
  begin
    out_d = out_q;
    case (mode)
      OCC_HIGH:
      begin
        if (hit_a)
          out_d = 1'b1;
      end
      OCC_LOW:
      begin
        if (hit_a)
          out_d = 1'b0;
      end
      OCC_TOGGLE:
      begin
        if (hit_a)
          out_d = ~out_q;
      end
      OCC_VFREQ:
      begin
        if (hit_a)
          out_d = ~out_q;
      end
      OCC_DUAL, OCC_DUALB, OCC_CENTER:
      begin
        // second value wins when both match together
        if (hit_b)
          out_d = 1'b0;
        else if (hit_a)
          out_d = 1'b1;
      end
      OCC_OFF, OCC_BAD:
      begin
        out_d = OUT_RESET;
      end
      default:
      begin
        out_d = OUT_RESET;
      end
    endcase
  end

  // output level register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= OUT_RESET;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  // next match events, one per matching cycle
  always_comb
  begin
    ma_d = hit_a;
    mb_d = hit_b;
  end

  // match event registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ma_q <= 1'b0;
      mb_q <= 1'b0;
    end
    else
    begin
      ma_q <= ma_d;
      mb_q <= mb_d;
    end
  end

  // next interrupt request, raised by a match on either value
  always_comb
  begin
    irq_d = |hit;
  end

  // interrupt request register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  // registered outputs
  assign cmp_out   = out_q;
  assign match_irq = irq_q;
  assign match_a   = ma_q;
  assign match_b   = mb_q;

endmodule // occ_channel

// >>> occ_chk.sv
// port assertions for the output compare channel
module occ_chk #(parameter int CW = 32) (
  input wire logic          sys_clk,
  input wire logic          rst_n,
  input wire logic [7:0]    channel_control_low,
  input wire logic [CW-1:0] timer_count,
  input wire logic [CW-1:0] cmp_a,
  input wire logic [CW-1:0] cmp_b,
  input wire logic          period_end,
  input wire logic          cmp_out,
  input wire logic          match_irq,
  input wire logic          match_a,
  input wire logic          match_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // selector, width and 16-bit hits
  wire [3:0] s = channel_control_low[3:0];
  wire       w = channel_control_low[5];
  wire       ha = timer_count[15:0] == cmp_a[15:0];
  wire       hb = timer_count[15:0] == cmp_b[15:0];
  sequence s_set;
    s == 4'h4 && !w && ha && !hb;
  endsequence
  a_irq_any: assert property (match_irq == (match_a | match_b)) else $error("irq mismatch");
  a_off_quiet: assert property (s == 4'h0 |=> !match_irq && !cmp_out) else $error("off active");
  a_high_set: assert property (s == 4'h1 && !w && ha |=> cmp_out && match_a) else $error("no set");
  a_wide_miss: assert property (s == 4'h1 && w && timer_count != cmp_a |=> !match_a) else $error("wide");
  a_low_clear: assert property (s == 4'h2 && timer_count == cmp_a |=> !cmp_out) else $error("no clear");
  a_toggle_flip: assert property ((s == 4'h3 || s == 4'h7) && timer_count == cmp_a
    |=> cmp_out != $past(cmp_out)) else $error("no toggle");
  a_dual_clear: assert property (s == 4'h4 && !w && hb |=> !cmp_out && match_b) else $error("dual");
  a_dual_hold: assert property (s_set ##1 (s == 4'h4 && !ha && !hb) |=> cmp_out) else $error("hold");
  a_wide_pwm: assert property (s inside {4'h4, 4'h5, 4'h6} && w |=> !cmp_out) else $error("pwm");
endmodule // occ_chk

bind occ_channel occ_chk #(.CW(CW)) occ_chk_i (.*);

// >>> occ_pkg.sv
// shared constants and types for the output compare channel
package occ_pkg;

  // control field positions
  localparam int MODE_LSB  = 0;
  localparam int MODE_MSB  = 3;
  localparam int WIDE_BIT  = 5;

  // selector codes
  localparam logic [3:0] SEL_OFF    = 4'h0;
  localparam logic [3:0] SEL_HIGH   = 4'h1;
  localparam logic [3:0] SEL_LOW    = 4'h2;
  localparam logic [3:0] SEL_TOGGLE = 4'h3;
  localparam logic [3:0] SEL_DUAL   = 4'h4;
  localparam logic [3:0] SEL_DUALB  = 4'h5;
  localparam logic [3:0] SEL_CENTER = 4'h6;
  localparam logic [3:0] SEL_VFREQ  = 4'h7;

  // reset values
  localparam logic       OUT_RESET  = 1'b0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // decoded operating mode, one-hot
  typedef enum logic [8:0] {
    OCC_OFF    = 9'h001,
    OCC_HIGH   = 9'h002,
    OCC_LOW    = 9'h004,
    OCC_TOGGLE = 9'h008,
    OCC_DUAL   = 9'h010,
    OCC_DUALB  = 9'h020,
    OCC_CENTER = 9'h040,
    OCC_VFREQ  = 9'h080,
    OCC_BAD    = 9'h100
  } occ_mode_t;

endpackage

// >>> occ_tb.sv
// self-checking bench for the output compare channel
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, rst_n = 0, period_end = 0, cmp_out, match_irq, match_a, match_b;
  logic [7:0]  channel_control_low = 8'h00;
  logic [27:0] hi = 28'h0;
  logic [31:0] timer_count, cmp_a = 0, cmp_b = 0;
  logic        eo = 0, ea = 0, eb = 0;
  logic [31:0] qa = 0, qb = 0;
  logic [3:0]  sp = 0;
  int          n_errors = 0, tests_run = 0;
  occ_channel occ_channel_i (.*);
  occ_tmr occ_tmr_i (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // reference step from the inputs the next edge samples
  task automatic model;
    logic [3:0] s;
    logic [31:0] m, ra, rb;
    logic w, d, v;
    s = channel_control_low[3:0];
    w = channel_control_low[5];
    d = s inside {4'h4, 4'h5, 4'h6};
    v = rst_n && s inside {[4'h1:4'h7]} && !(d && w);
    m = w ? 32'hFFFFFFFF : 32'h0000FFFF;
    ra = (s == 4'h5 || s == 4'h6) ? qa : cmp_a;
    rb = (s == 4'h5 || s == 4'h6) ? qb : cmp_b;
    ea = v && (timer_count & m) == (ra & m);
    eb = v && d && (timer_count & m) == (rb & m);
    if (!v) eo = 0;
    else if (d) eo = !eb && (ea || eo);
    else if (s == 4'h1) eo = ea | eo;
    else if (s == 4'h2) eo = !ea & eo;
    else eo = ea ^ eo;
    // buffered copies follow period end and selector changes
    if (period_end || s != sp) {qa, qb} = {cmp_a, cmp_b};
    if (!rst_n) {qa, qb} = 64'h0;
    sp = rst_n ? s : 4'h0;
  endtask
  // every selector and width, twice, a reset in mid-run
  initial
  begin
    void'($urandom(42));
    repeat (12) @(negedge sys_clk);
    rst_n = 1;
    for (int k = 0; k < 64; k++)
      for (int j = 0; j < 20; j++)
      begin
        @(negedge sys_clk);
        chk("cmp_out", cmp_out, eo);
        chk("match_a", match_a, ea);
        chk("match_b", match_b, eb);
        chk("match_irq", match_irq, ea | eb);
        if (j == 0 || j == 10)
        begin
          hi = 28'($urandom);
          cmp_a = {($urandom & 1) ? hi : 28'($urandom), 4'($urandom)};
          cmp_b = {hi, 4'($urandom)};
        end
        channel_control_low = (j == 0) ? 8'h00 : {2'b00, k[0], 1'b0, k[4:1]};
        period_end = (j == 0 || j == 15);
        rst_n = !(k == 40 && j == 5);
        #1 model;
      end
    complete_run;
  end
  // hang guard
  initial
  begin
    #100000;
    n_errors++;
    complete_run;
  end
endmodule // testbench

// >>> occ_tmr.sv
// timer partner: running count under a settable upper part
module occ_tmr (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [27:0] hi,
  output logic     [31:0] timer_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // low nibble steps every rising edge and wraps
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  assign timer_count = {hi, cnt_q};
endmodule // occ_tmr
